// file: design/cicr_regs.sv
// interrupt control and clear-written registers of a crypto control block,
// reached as an avalon-mm slave with waitrequest.
// assumes engines and the descriptor controller share clk_in; their
// event and level inputs are therefore used without synchronisers.
//
// Overview of operation
// [R1] rng, hash and pubkey error flags read at bits 25, 23, 22.
// [R2] stream, des and aes error flags read at bits 19, 18, 17.
// [R3] bit 9 shows rng done; write 1 clears, 0 keeps.
// [R4] bit 7 shows hash done; write 1 clears, 0 keeps.
// [R5] bit 6 shows pubkey done; write 1 clears, 0 keeps.
// [R6] bit 3 shows stream cipher done; write 1 clears, 0 keeps.
// [R7] bit 2 shows des done; write 1 clears, 0 keeps.
// [R8] every clear-written field is a one-cycle strobe that self-clears.
// [R9] the controller writes clear-written between shared descriptors when needed.
// [R10] bit 31 flushes input data fifo and information fifo.
// [R11] bit 30 flushes the output data fifo.
// [R12] bits 29 and 28 reset the selected class 1 / class 2 engine.
// [R13] bits 27 and 26 clear class 1 / class 2 done interrupt.
// [R14] bit 25 clears the shared-descriptor indication.
// [R15] under direct software control bit 25 leaves sharing state alone.
// [R16] bits 22 and 6 clear class 2 / class 1 key and key size.
// [R17] bits 21 and 5 clear class 2 / class 1 context.
// [R18] bit 18 clears class 2 data size and icv size.
// [R19] bit 16 clears the class 2 mode register.
// [R20] bits 15..12 clear pubkey e, n, b, a size registers.
// [R21] bit 3 clears the class 1 icv size register.
// [R22] bit 2 clears class 1 data size and aad size together.
// [R23] bit 0 clears the class 1 mode register.
// [R24] both registers reachable only with request and enable bits set.
// [R25] zeros, reserved bits and error-flag writes have no effect.
// [R26] several strobes in one write all act in that write.

`timescale 1ns/100ps

module cicr_regs (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [cicr_pkg::CICR_AW-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [cicr_pkg::CICR_DW-1:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [cicr_pkg::CICR_DW-1:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic [cicr_pkg::CICR_NENG-1:0] engine_error_in,
    input wire logic [cicr_pkg::CICR_NENG-1:0] engine_done_in,
    input wire logic share_set_in,
    output logic [cicr_pkg::CICR_DW-1:0] clear_strobes_out,
    output logic shared_desc_out
);
    import cicr_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic wait_q;
    logic [CICR_DW-1:0] rdata_q;
    logic [CICR_DW-1:0] rdata_d;
    logic [CICR_CTRL_W-1:0] ctrl_q;
    logic [CICR_NENG-1:0] error_flag_q;
    logic [CICR_NENG-1:0] done_flag_q;
    logic [CICR_NENG-1:0] done_clr;
    logic [CICR_DW-1:0] strobe_q;
    logic [CICR_DW-1:0] strobe_d;
    logic shared_q;
    logic [CICR_DW-1:0] wmask;
    logic [CICR_DW-1:0] wdata_m;
    logic [CICR_DW-1:0] ictl_view;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire logic req = avs_read_in | avs_write_in;
    wire logic wr_acc = avs_write_in & ~wait_q;
    wire logic sel_ctrl = (avs_address_in == CICR_CTRL_OFS);
    wire logic sel_ictl = (avs_address_in == CICR_ICTL_OFS);
    wire logic sel_cwr = (avs_address_in == CICR_CWR_OFS);
    wire logic gate = ctrl_q[CICR_CTRL_REQ_POS] & ctrl_q[CICR_CTRL_EN_POS];
    wire logic sw_mode = ctrl_q[CICR_CTRL_SW_POS];
    wire logic ictl_wr = wr_acc & sel_ictl & gate; // R24
    wire logic cwr_wr = wr_acc & sel_cwr & gate; // R24

    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : g_lane
            assign wmask[gb*8 +: 8] = {8{avs_byteenable_in[gb]}};
        end
    endgenerate

    assign wdata_m = avs_writedata_in & wmask;

    // ------------------------------------------------------------
    // waitrequest: one wait cycle, then the access edge
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~(req & wait_q);
        end
    end

    assign avs_waitrequest_out = wait_q;

    // ------------------------------------------------------------
    // controller request register
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl_q <= CICR_CTRL_RST;
        end else if (wr_acc && sel_ctrl) begin
            ctrl_q <= wdata_m[CICR_CTRL_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // per-engine error and done flags
    // ------------------------------------------------------------
    genvar ge;
    generate
        for (ge = 0; ge < CICR_NENG; ge++) begin : g_eng
            // only the done positions are writable; error bits ignore writes
            assign done_clr[ge] = ictl_wr & wdata_m[CICR_DONE_POS[ge]]; // R25
            assign ictl_view[CICR_ERR_POS[ge]] = error_flag_q[ge]; // R1 R2
            assign ictl_view[CICR_DONE_POS[ge]] = done_flag_q[ge];
        end
    endgenerate

    // reserved ictl positions read as zero
    generate
        for (gb = 0; gb < CICR_DW; gb++) begin : g_rsv
            if (gb != 1 && gb != 2 && gb != 3 && gb != 6 && gb != 7 &&
                gb != 9 && gb != 17 && gb != 18 && gb != 19 &&
                gb != 22 && gb != 23 && gb != 25) begin : g_z
                assign ictl_view[gb] = 1'b0;
            end
        end
    endgenerate

    // error flags follow the engines' error levels
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            error_flag_q <= CICR_FLAG_RST;
        end else begin
            error_flag_q <= engine_error_in; // R1 R2
        end
    end

    // done flags: sticky, write one to clear, a new event beats the clear
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            done_flag_q <= CICR_FLAG_RST;
        end else begin
            done_flag_q <= (done_flag_q & ~done_clr) | engine_done_in; // R3 R4 R5 R6 R7
        end
    end

    // ------------------------------------------------------------
    // clear-written strobes
    // ------------------------------------------------------------
    always_comb begin
        strobe_d = CICR_WORD_RST;
        if (cwr_wr) begin
            // every selected field fires together, reserved bits dropped
            strobe_d = wdata_m & CICR_CWR_MASK; // R25 R26 R10 R11 R12 R13
            // R16 R17 R18 R19 R20 R21 R22 R23 map one to one
            if (sw_mode) begin
                strobe_d[CWR_CLR_SHARE] = 1'b0; // R15
            end
        end
    end

    // strobes live one cycle, then drop by themselves
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            strobe_q <= CICR_WORD_RST;
        end else begin
            strobe_q <= strobe_d; // R8
        end
    end

    assign clear_strobes_out = strobe_q;

    // ------------------------------------------------------------
    // shared-descriptor indication
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            shared_q <= 1'b0;
        end else if (share_set_in) begin
            shared_q <= 1'b1;
        end else if (strobe_d[CWR_CLR_SHARE]) begin
            shared_q <= 1'b0; // R14
        end
    end

    assign shared_desc_out = shared_q;

    // ------------------------------------------------------------
    // read path: data captured on the wait cycle
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = CICR_WORD_RST;
        if (sel_ctrl) begin
            rdata_d[CICR_CTRL_W-1:0] = ctrl_q;
        end else if (sel_ictl && gate) begin
            rdata_d = ictl_view; // R24
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_q <= CICR_WORD_RST;
        end else if (avs_read_in && wait_q) begin
            rdata_q <= rdata_d;
        end
    end

    assign avs_readdata_out = rdata_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    sequence s_ictl_w1(int i);
        ictl_wr && wdata_m[CICR_DONE_POS[i]] && !engine_done_in[i];
    endsequence

    sequence s_cwr_bit(int b);
        cwr_wr && wdata_m[b];
    endsequence

    property p_w1c(int i);
        s_ictl_w1(i) |=> !done_flag_q[i];
    endproperty

    property p_strobe(int b);
        s_cwr_bit(b) |=> strobe_q[b] ##1 (strobe_q[b] == $past(cwr_wr));
    endproperty

    a_err_readback: assert property ( // R1
        (avs_read_in && wait_q && sel_ictl && gate)
        |=> avs_readdata_out[25] == $past(error_flag_q[CICR_ENG_RNG])
            && avs_readdata_out[23] == $past(error_flag_q[CICR_ENG_HASH])
            && avs_readdata_out[22] == $past(error_flag_q[CICR_ENG_PK]))
        else $error("error flag readback wrong");

    a_err_readback_lo: assert property ( // R2
        (avs_read_in && wait_q && sel_ictl && gate)
        |=> avs_readdata_out[19] == $past(error_flag_q[CICR_ENG_STREAM])
            && avs_readdata_out[18] == $past(error_flag_q[CICR_ENG_DES])
            && avs_readdata_out[17] == $past(error_flag_q[CICR_ENG_AES]))
        else $error("low error flag readback wrong");

    a_err_track: assert property ( // R2
        error_flag_q[CICR_ENG_AES] == $past(engine_error_in[CICR_ENG_AES]))
        else $error("aes error flag does not follow engine");

    a_rng_w1c: assert property (p_w1c(CICR_ENG_RNG)) // R3
        else $error("rng done flag not cleared by write one");

    a_hash_w1c: assert property (p_w1c(CICR_ENG_HASH)) // R4
        else $error("hash done flag not cleared by write one");

    a_pk_w1c: assert property (p_w1c(CICR_ENG_PK)) // R5
        else $error("pubkey done flag not cleared by write one");

    a_stream_w1c: assert property (p_w1c(CICR_ENG_STREAM)) // R6
        else $error("stream done flag not cleared by write one");

    a_des_w1c: assert property (p_w1c(CICR_ENG_DES)) // R7
        else $error("des done flag not cleared by write one");

    a_done_sticky: assert property ( // R3
        (done_flag_q[CICR_ENG_RNG] && !done_clr[CICR_ENG_RNG])
        |=> done_flag_q[CICR_ENG_RNG])
        else $error("rng done flag lost without clear");

    a_done_set_wins: assert property ( // R4
        engine_done_in[CICR_ENG_HASH] |=> done_flag_q[CICR_ENG_HASH])
        else $error("hash done event lost");

    a_strobe_oneshot: assert property ( // R8
        (strobe_q != CICR_WORD_RST && !cwr_wr) |=> strobe_q == CICR_WORD_RST)
        else $error("strobe did not self-clear");

    a_flush_in: assert property (p_strobe(CWR_FLUSH_IN)) // R10
        else $error("input fifo flush strobe wrong");

    a_flush_out: assert property (p_strobe(CWR_FLUSH_OUT)) // R11
        else $error("output fifo flush strobe wrong");

    a_engine_reset: assert property (p_strobe(CWR_RST_C2)) // R12
        else $error("class 2 engine reset strobe wrong");

    a_class1_reset: assert property (p_strobe(CWR_RST_C1)) // R12
        else $error("class 1 engine reset strobe wrong");

    a_c1_done_clear: assert property (p_strobe(CWR_CLR_C1_DONE)) // R13
        else $error("class 1 done clear strobe wrong");

    a_c2_done_clear: assert property (p_strobe(CWR_CLR_C2_DONE)) // R13
        else $error("class 2 done clear strobe wrong");

    a_c2_key_clear: assert property (p_strobe(CWR_CLR_C2_KEY)) // R16
        else $error("class 2 key clear strobe wrong");

    a_c1_key_clear: assert property (p_strobe(CWR_CLR_C1_KEY)) // R16
        else $error("class 1 key clear strobe wrong");

    a_c2_ctx_clear: assert property (p_strobe(CWR_CLR_C2_CTX)) // R17
        else $error("class 2 context clear strobe wrong");

    a_c1_ctx_clear: assert property (p_strobe(CWR_CLR_C1_CTX)) // R17
        else $error("class 1 context clear strobe wrong");

    a_c2_size_clear: assert property (p_strobe(CWR_CLR_C2_SIZES)) // R18
        else $error("class 2 size clear strobe wrong");

    a_c2_mode_clear: assert property (p_strobe(CWR_CLR_C2_MODE)) // R19
        else $error("class 2 mode clear strobe wrong");

    a_pk_e_clear: assert property (p_strobe(CWR_CLR_PK_E)) // R20
        else $error("pubkey e size clear strobe wrong");

    a_pk_n_clear: assert property (p_strobe(CWR_CLR_PK_N)) // R20
        else $error("pubkey n size clear strobe wrong");

    a_pk_b_clear: assert property (p_strobe(CWR_CLR_PK_B)) // R20
        else $error("pubkey b size clear strobe wrong");

    a_pk_a_clear: assert property (p_strobe(CWR_CLR_PK_A)) // R20
        else $error("pubkey a size clear strobe wrong");

    a_c1_icv_clear: assert property (p_strobe(CWR_CLR_C1_ICV)) // R21
        else $error("class 1 icv size clear strobe wrong");

    a_c1_dsz_clear: assert property (p_strobe(CWR_CLR_C1_DSZ)) // R22
        else $error("class 1 data size clear strobe wrong");

    a_c1_mode_clear: assert property (p_strobe(CWR_CLR_C1_MODE)) // R23
        else $error("class 1 mode clear strobe wrong");

    a_share_clear: assert property ( // R14
        (s_cwr_bit(CWR_CLR_SHARE) and (!sw_mode && !share_set_in))
        |=> !shared_q)
        else $error("shared indication not cleared");

    a_share_keep: assert property ( // R15
        (sw_mode && shared_q && !(wr_acc && sel_ctrl)) |=> shared_q)
        else $error("sharing altered under software control");

    a_gate_block: assert property ( // R24
        (wr_acc && sel_cwr && !gate) |=> strobe_q == CICR_WORD_RST)
        else $error("clear-written acted without request and enable");

    a_reserved_zero: assert property ( // R25
        (strobe_q & ~CICR_CWR_MASK) == CICR_WORD_RST)
        else $error("reserved strobe bit fired");

    a_multi_strobe: assert property ( // R26
        (cwr_wr && !sw_mode)
        |=> strobe_q == ($past(wdata_m) & CICR_CWR_MASK))
        else $error("multi-bit clear-written write incomplete");

    a_bus_answer: assert property (
        (req && wait_q) |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
        else $error("waitrequest handshake wrong");

endmodule : cicr_regs

// file: design/cicr_pkg.sv
// constants for the crypto engine interrupt control and clear-written
// register pair; assumes a 32-bit avalon-mm slave with byte addressing.
package cicr_pkg;

    // ------------------------------------------------------------
    // bus and register map
    // ------------------------------------------------------------
    localparam int CICR_AW = 8;
    localparam int CICR_DW = 32;
    localparam logic [CICR_AW-1:0] CICR_CTRL_OFS = 8'h00;
    localparam logic [CICR_AW-1:0] CICR_ICTL_OFS = 8'h3c;
    localparam logic [CICR_AW-1:0] CICR_CWR_OFS = 8'h40;

    // ------------------------------------------------------------
    // controller request register fields
    // ------------------------------------------------------------
    localparam int CICR_CTRL_W = 3;
    localparam int CICR_CTRL_REQ_POS = 0;
    localparam int CICR_CTRL_EN_POS = 1;
    localparam int CICR_CTRL_SW_POS = 2;
    localparam logic [CICR_CTRL_W-1:0] CICR_CTRL_RST = 3'h0;

    // ------------------------------------------------------------
    // engines: 0 aes, 1 des, 2 stream cipher, 3 pubkey, 4 hash, 5 rng
    // ------------------------------------------------------------
    localparam int CICR_NENG = 6;
    localparam int CICR_ENG_AES = 0;
    localparam int CICR_ENG_DES = 1;
    localparam int CICR_ENG_STREAM = 2;
    localparam int CICR_ENG_PK = 3;
    localparam int CICR_ENG_HASH = 4;
    localparam int CICR_ENG_RNG = 5;
    localparam int CICR_ERR_POS [CICR_NENG] = '{17, 18, 19, 22, 23, 25};
    localparam int CICR_DONE_POS [CICR_NENG] = '{1, 2, 3, 6, 7, 9};
    localparam logic [CICR_NENG-1:0] CICR_FLAG_RST = 6'h00;

    // ------------------------------------------------------------
    // clear-written strobe positions
    // ------------------------------------------------------------
    localparam int CWR_FLUSH_IN = 31;
    localparam int CWR_FLUSH_OUT = 30;
    localparam int CWR_RST_C1 = 29;
    localparam int CWR_RST_C2 = 28;
    localparam int CWR_CLR_C1_DONE = 27;
    localparam int CWR_CLR_C2_DONE = 26;
    localparam int CWR_CLR_SHARE = 25;
    localparam int CWR_CLR_C2_KEY = 22;
    localparam int CWR_CLR_C2_CTX = 21;
    localparam int CWR_CLR_C2_SIZES = 18;
    localparam int CWR_CLR_C2_MODE = 16;
    localparam int CWR_CLR_PK_E = 15;
    localparam int CWR_CLR_PK_N = 14;
    localparam int CWR_CLR_PK_B = 13;
    localparam int CWR_CLR_PK_A = 12;
    localparam int CWR_CLR_C1_KEY = 6;
    localparam int CWR_CLR_C1_CTX = 5;
    localparam int CWR_CLR_C1_ICV = 3;
    localparam int CWR_CLR_C1_DSZ = 2;
    localparam int CWR_CLR_C1_MODE = 0;
    localparam logic [CICR_DW-1:0] CICR_CWR_MASK = 32'hfe65_f06d;
    localparam logic [CICR_DW-1:0] CICR_WORD_RST = 32'h0000_0000;

endpackage : cicr_pkg

// file: test/cicr_eng_model.sv
// engine side model: request edges become one-cycle done pulses, error
// levels follow the requests, and a request edge marks a shared descriptor.
// assumes the bench changes the requests just after clk_in edges.
`timescale 1ns/100ps
module cicr_eng_model (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [cicr_pkg::CICR_NENG-1:0] done_req_in,
    input wire logic [cicr_pkg::CICR_NENG-1:0] err_req_in,
    input wire logic share_req_in,
    output logic [cicr_pkg::CICR_NENG-1:0] done_out,
    output logic [cicr_pkg::CICR_NENG-1:0] err_out,
    output logic share_out
);
    import cicr_pkg::*;
    logic [CICR_NENG-1:0] done_req_q;
    logic share_req_q;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            done_req_q <= '0;
            share_req_q <= 1'b0;
            done_out <= '0;
            err_out <= '0;
            share_out <= 1'b0;
        end else begin
            done_req_q <= done_req_in;
            share_req_q <= share_req_in;
            done_out <= done_req_in & ~done_req_q;
            err_out <= err_req_in;
            share_out <= share_req_in & ~share_req_q;
        end
    end
endmodule : cicr_eng_model

// file: test/cicr_regs_tb.sv
// self-checking bench for the interrupt control and clear-written pair.
// assumes one clock; engines are modelled by cicr_eng_model.
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module cicr_regs_tb;
    import cicr_pkg::*;
    typedef struct {logic [2:0] c; logic [31:0] d; logic [3:0] be;
        logic [31:0] x;} cicr_row_t;
    logic clk_in = 1'b0, resetn_in = 1'b0, avs_read_in = 1'b0;
    logic avs_write_in = 1'b0, share_req = 1'b0;
    logic [7:0] avs_address_in = 8'h00;
    logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
    logic [31:0] clear_strobes_out, q, ev, seen;
    logic [3:0] avs_byteenable_in = 4'hf;
    logic [5:0] done_req = 6'h00, err_req = 6'h00, done_w, err_w;
    logic avs_waitrequest_out, shared_desc_out, share_w;
    int failures = 0, n_tests = 0, cyc;
    cicr_row_t rows [8] = '{
        '{3'h3, 32'hffff_ffff, 4'hf, CICR_CWR_MASK},
        '{3'h3, 32'h8000_0001, 4'hf, 32'h8000_0001},
        '{3'h3, 32'hffff_ffff, 4'h1, 32'h0000_006d},
        '{3'h1, 32'hffff_ffff, 4'hf, 32'h0},
        '{3'h2, 32'hffff_ffff, 4'hf, 32'h0},
        '{3'h0, 32'hffff_ffff, 4'hf, 32'h0},
        '{3'h7, 32'h0200_0000, 4'hf, 32'h0},
        '{3'h7, 32'hffff_ffff, 4'hf, 32'hfc65_f06d}};
    always #2 clk_in = ~clk_in;
    cicr_eng_model eng (.clk_in(clk_in), .resetn_in(resetn_in),
        .done_req_in(done_req), .err_req_in(err_req),
        .share_req_in(share_req), .done_out(done_w), .err_out(err_w),
        .share_out(share_w));
    cicr_regs uut (.clk_in(clk_in), .resetn_in(resetn_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out),
        .engine_error_in(err_w), .engine_done_in(done_w),
        .share_set_in(share_w), .clear_strobes_out(clear_strobes_out),
        .shared_desc_out(shared_desc_out));
    // collects every strobe bit and counts the cycles with any strobe up
    always @(posedge clk_in) begin
        if (clear_strobes_out != 32'h0) begin
            seen <= seen | clear_strobes_out;
            cyc <= cyc + 1;
        end
    end
    // --------------------------------------------------------
    // bus access, verdict
    // --------------------------------------------------------
    task automatic acc(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_byteenable_in <= be;
        avs_write_in <= w;
        avs_read_in <= !w;
        do begin
            @(posedge clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 40);
        if (n >= 40) failures++;
        q = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask : acc
    task automatic cwr(input logic [2:0] c, input logic [31:0] d,
        input logic [3:0] be);
        acc(1'b1, CICR_CTRL_OFS, {29'h0, c}, 4'hf);
        seen = 32'h0;
        cyc = 0;
        acc(1'b1, CICR_CWR_OFS, d, be);
        repeat (2) @(posedge clk_in);
    endtask : cwr
    task automatic wait_n(input int k);
        repeat (k) @(posedge clk_in);
    endtask : wait_n
    task wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up
    initial begin
        #(20000 * 4);
        failures++;
        wrap_up;
    end
    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        wait_n(4);
        `CHK(avs_waitrequest_out, 1'b1)
        `CHK(clear_strobes_out, 32'h0)
        resetn_in <= 1'b1;
        acc(1'b0, CICR_CTRL_OFS, 32'h0, 4'hf);
        `CHK(q, 32'h0)
        foreach (rows[i]) begin
            cwr(rows[i].c, rows[i].d, rows[i].be);
            `CHK(seen, rows[i].x)
            `CHK(cyc, (rows[i].x != 0) ? 1 : 0)
        end
        for (int i = 0; i < 32; i++) begin
            cwr(3'h3, 32'h1 << i, 4'hf);
            `CHK(seen, CICR_CWR_MASK & (32'h1 << i))
        end
        $display("test strobe fields done");
        seen = 32'h0;
        cyc = 0;
        acc(1'b1, CICR_CWR_OFS, 32'h1, 4'hf);
        acc(1'b1, CICR_CWR_OFS, 32'h4, 4'hf);
        wait_n(2);
        `CHK(seen, 32'h5)
        `CHK(cyc, 2)
        acc(1'b1, 8'h44, 32'hffff_ffff, 4'hf);
        acc(1'b0, 8'h44, 32'h0, 4'hf);
        `CHK(q, 32'h0)
        acc(1'b1, CICR_CTRL_OFS, 32'hffff_ffff, 4'hf);
        acc(1'b0, CICR_CTRL_OFS, 32'h0, 4'hf);
        `CHK(q, 32'h7)
        $display("test back to back and unmapped done");
        acc(1'b1, CICR_CTRL_OFS, 32'h3, 4'hf);
        err_req <= 6'h3f;
        done_req <= 6'h3f;
        wait_n(4);
        ev = 32'h0;
        for (int e = 0; e < CICR_NENG; e++) begin
            ev[CICR_ERR_POS[e]] = 1'b1;
            ev[CICR_DONE_POS[e]] = 1'b1;
        end
        acc(1'b1, CICR_ICTL_OFS, 32'h0, 4'hf);
        acc(1'b1, CICR_ICTL_OFS, 32'h02ec_0000, 4'hf);
        acc(1'b0, CICR_ICTL_OFS, 32'h0, 4'hf);
        `CHK(q, ev)
        for (int e = CICR_NENG - 1; e >= 0; e--) begin
            acc(1'b1, CICR_ICTL_OFS, 32'h1 << CICR_DONE_POS[e], 4'hf);
            ev[CICR_DONE_POS[e]] = 1'b0;
            acc(1'b0, CICR_ICTL_OFS, 32'h0, 4'hf);
            `CHK(q, ev)
        end
        err_req <= 6'h00;
        done_req <= 6'h00;
        wait_n(3);
        acc(1'b0, CICR_ICTL_OFS, 32'h0, 4'hf);
        `CHK(q, 32'h0)
        $display("test flags done");
        acc(1'b1, CICR_CTRL_OFS, 32'h1, 4'hf);
        done_req <= 6'h20;
        wait_n(4);
        acc(1'b0, CICR_ICTL_OFS, 32'h0, 4'hf);
        `CHK(q, 32'h0)
        acc(1'b1, CICR_ICTL_OFS, 32'h0000_0200, 4'hf);
        acc(1'b1, CICR_CTRL_OFS, 32'h3, 4'hf);
        acc(1'b0, CICR_ICTL_OFS, 32'h0, 4'hf);
        `CHK(q, 32'h0000_0200)
        $display("test gating done");
        share_req <= 1'b1;
        wait_n(4);
        `CHK(shared_desc_out, 1'b1)
        cwr(3'h7, 32'h0200_0000, 4'hf);
        `CHK(shared_desc_out, 1'b1)
        cwr(3'h3, 32'h0200_0000, 4'hf);
        `CHK(shared_desc_out, 1'b0)
        $display("test sharing done");
        done_req <= 6'h00;
        share_req <= 1'b0;
        resetn_in <= 1'b0;
        wait_n(2);
        `CHK(avs_waitrequest_out, 1'b1)
        `CHK(shared_desc_out, 1'b0)
        resetn_in <= 1'b1;
        acc(1'b0, CICR_CTRL_OFS, 32'h0, 4'hf);
        `CHK(q, 32'h0)
        acc(1'b1, CICR_CTRL_OFS, 32'h3, 4'hf);
        acc(1'b0, CICR_ICTL_OFS, 32'h0, 4'hf);
        `CHK(q, 32'h0)
        $display("test mid-run reset done");
        wrap_up;
    end
endmodule : cicr_regs_tb
